// File: verilog/sfi_indicator.v
/*
 * Fault relay and status indicator logic of a managed switch, with an
 * Avalon-MM register slave for masks, modes and manual relay control.
 * Assumes all inputs synchronous to clk_sys; relay driver outside.
 */
//
// Operation
// - Relay contact is closed with no fault, opened on any reportable fault.
// - Either supply input below threshold opens the contact.
// - Device not operational opens the contact.
// - Link loss on an unmasked port opens the contact.
// - After reset all per-port link monitoring is disabled.
// - Loss of ring redundancy reserve opens the contact.
// - Self-test error opens the contact.
// - Incorrect ring configuration opens the contact.
// - As ring manager, reserve available is also reported; monitoring off after reset.
// - Management may drive the contact manually, overriding monitoring.
// - Power LED green both supplies, yellow one, dark none.
// - Fault LED red while contact open, dark while closed.
// - Under manual control the fault LED shows detected errors instead.
// - Ring manager LED green port off, yellow port on, dark inactive.
// - Ring manager LED flashes green on incorrect ring configuration.
// - Stand-by LED green when stand-by mode enabled.
// - Link LED steady on valid link, dark otherwise, 1/s flash in stand-by.
// - Link LED flashes 3/s when port disabled.
// - Activity LED flashes during reception, dark otherwise.
// - During boot the port LEDs show boot progress.
// - Initialisation and self-test take about sixty seconds before normal indication.
// - Operation starts at power-up with no enable command.
//
`timescale 1ns/100ps
`include "sfi_regs.vh"

module sfi_indicator #(
    parameter SLOW_HALF = `SFI_SLOW_HALF,
    parameter FAST_HALF = `SFI_FAST_HALF,
    parameter SEC_CYCLES = `SFI_CLK_HZ,
    parameter STARTUP_S = `SFI_STARTUP_S,
    parameter ACT_CYCLES = `SFI_ACT_CYCLES
) (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg [1:0] avs_response,
    input wire supply_input_one,
    input wire supply_input_two,
    input wire dev_operational,
    input wire selftest_error,
    input wire selftest_done,
    input wire ring_reserve_lost,
    input wire ring_config_bad,
    input wire ring_port_enabled,
    input wire [`SFI_PORTS-1:0] port_link_up,
    input wire [`SFI_PORTS-1:0] port_rx,
    input wire [`SFI_PORTS-1:0] boot_progress,
    output reg relay_closed,
    output reg led_power_green,
    output reg led_power_yellow,
    output reg led_fault_red,
    output reg led_rm_green,
    output reg led_rm_yellow,
    output reg led_standby_green,
    output reg [`SFI_PORTS-1:0] port_link_indicator,
    output reg [`SFI_PORTS-1:0] port_activity_indicator
);

    localparam NP = `SFI_PORTS;

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg [31:0] ctrl;
    reg [NP-1:0] link_mask;
    reg [2*NP-1:0] port_mode;
    reg [7:0] startup_sec;
    reg startup_done;
    reg [31:0] next_readdata;
    reg [31:0] wmask;
    reg bus_phase;
    wire slow_phase;
    wire fast_phase;
    wire sec_tick;
    wire manual_en;
    wire manual_open;
    wire ring_mon_en;
    wire rm_en;
    wire standby_en;
    wire booting;
    wire link_fault;
    wire ring_fault;
    wire fault_detect;
    wire supply_fault;
    wire [NP-1:0] next_link_led;
    wire [NP-1:0] next_act_led;

    assign manual_en = ctrl[`SFI_CTRL_MANUAL_EN];
    assign manual_open = ctrl[`SFI_CTRL_MANUAL_OPEN];
    assign ring_mon_en = ctrl[`SFI_CTRL_RING_MON_EN];
    assign rm_en = ctrl[`SFI_CTRL_RM_EN];
    assign standby_en = ctrl[`SFI_CTRL_STANDBY_EN];

    // ****************************************************************
    // Time base
    // ****************************************************************
    // Free-running flash phases and seconds tick
    sfi_timebase #(
        .SLOW_HALF(SLOW_HALF),
        .FAST_HALF(FAST_HALF),
        .SEC_CYCLES(SEC_CYCLES)
    ) u_timebase (
        .clk_sys(clk_sys),
        .rst(rst),
        .slow_phase(slow_phase),
        .fast_phase(fast_phase),
        .sec_tick(sec_tick)
    );

    // ****************************************************************
    // Start-up phase
    // ****************************************************************
    // Counts seconds until both the time and the self-test are done
    always @(posedge clk_sys) begin
        if (rst) begin
            startup_sec <= 8'h00;
            startup_done <= 1'b0;
        end else if (!startup_done) begin
            if (sec_tick && startup_sec < STARTUP_S) begin
                startup_sec <= startup_sec + 8'h01;
            end
            if (startup_sec >= STARTUP_S && selftest_done) begin
                startup_done <= 1'b1;
            end
        end
    end

    assign booting = !startup_done && !ctrl[`SFI_CTRL_BOOT_DONE];

    // ****************************************************************
    // Fault combination
    // ****************************************************************
    // Link faults only count for ports enabled in the mask
    assign link_fault = |(~port_link_up & link_mask);
    // Reserve loss, bad config, and reserve-available in manager mode
    assign ring_fault = ring_mon_en && (ring_reserve_lost || ring_config_bad
        || (rm_en && !ring_reserve_lost));
    assign supply_fault = !supply_input_one || !supply_input_two;
    assign fault_detect = supply_fault || !dev_operational
        || selftest_error || link_fault || ring_fault;

    // ****************************************************************
    // Device LEDs and relay
    // ****************************************************************
    // Relay closed means no fault; manual mode overrides
    always @(posedge clk_sys) begin
        if (rst) begin
            relay_closed <= 1'b0;
            led_fault_red <= 1'b1;
            led_power_green <= 1'b0;
            led_power_yellow <= 1'b0;
            led_rm_green <= 1'b0;
            led_rm_yellow <= 1'b0;
            led_standby_green <= 1'b0;
        end else begin
            if (manual_en) begin
                relay_closed <= !manual_open;
                led_fault_red <= fault_detect;
            end else begin
                relay_closed <= !fault_detect;
                led_fault_red <= fault_detect;
            end
            led_power_green <= supply_input_one && supply_input_two;
            led_power_yellow <= supply_input_one ^ supply_input_two;
            if (!rm_en) begin
                led_rm_green <= 1'b0;
                led_rm_yellow <= 1'b0;
            end else if (ring_config_bad) begin
                led_rm_green <= slow_phase;
                led_rm_yellow <= 1'b0;
            end else begin
                led_rm_green <= !ring_port_enabled;
                led_rm_yellow <= ring_port_enabled;
            end
            led_standby_green <= standby_en;
        end
    end

    // ****************************************************************
    // Port LEDs
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi = gi + 1) begin : g_port
            reg [31:0] act_cnt;
            reg act_bit;
            wire [1:0] mode;
            assign mode = port_mode[2*gi+1:2*gi];
            // Link LED by port mode and link state
            assign next_link_led[gi] = booting ? boot_progress[gi] :
                (mode == `SFI_MODE_DISABLED) ? fast_phase :
                (mode == `SFI_MODE_STANDBY) ? slow_phase :
                port_link_up[gi];
            // Period restarts only after expiry, so steady reception still flashes
            always @(posedge clk_sys) begin
                if (rst) begin
                    act_cnt <= 32'h00000000;
                end else if (act_cnt != 32'h00000000) begin
                    act_cnt <= act_cnt - 32'h00000001;
                end else if (port_rx[gi]) begin
                    act_cnt <= ACT_CYCLES;
                end
            end
            // Toggle at each period start while receiving, dark once idle
            always @(posedge clk_sys) begin
                if (rst) begin
                    act_bit <= 1'b0;
                end else if (act_cnt == 32'h00000000) begin
                    act_bit <= port_rx[gi] ? ~act_bit : 1'b0;
                end
            end
            assign next_act_led[gi] = booting ? boot_progress[gi] : act_bit;
        end
    endgenerate

    // Registered port outputs
    always @(posedge clk_sys) begin
        if (rst) begin
            port_link_indicator <= {NP{1'b0}};
            port_activity_indicator <= {NP{1'b0}};
        end else begin
            port_link_indicator <= next_link_led;
            port_activity_indicator <= next_act_led;
        end
    end

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    // Byte enables expanded to a bit mask
    always @* begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                 {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    end

    // Read mux
    always @* begin
        next_readdata = 32'h00000000;
        case (avs_address)
            `SFI_OFF_CTRL: next_readdata = {26'h0000000, ctrl[5:0]};
            `SFI_OFF_LINK_MASK: next_readdata = {23'h000000, link_mask};
            `SFI_OFF_PORT_MODE: next_readdata = {14'h0000, port_mode};
            `SFI_OFF_STATUS: next_readdata = {26'h0000000, startup_done, selftest_error,
                supply_input_two, supply_input_one, fault_detect, !relay_closed};
            `SFI_OFF_PORT_STAT: next_readdata = {23'h000000, port_link_up};
            default: next_readdata = 32'h00000000;
        endcase
    end

    // One wait cycle, then answer on the second edge
    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= `SFI_CTRL_RESET;
            link_mask <= `SFI_LINK_MASK_RESET;
            port_mode <= `SFI_MODE_RESET;
            bus_phase <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            avs_response <= 2'h0;
        end else if ((avs_read || avs_write) && !bus_phase) begin
            bus_phase <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? next_readdata : 32'h00000000;
            avs_response <= (avs_address == `SFI_OFF_CTRL || avs_address == `SFI_OFF_LINK_MASK
                || avs_address == `SFI_OFF_PORT_MODE || avs_address == `SFI_OFF_STATUS
                || avs_address == `SFI_OFF_PORT_STAT) ? 2'h0 : 2'h3;
            if (avs_write) begin
                case (avs_address)
                    `SFI_OFF_CTRL: ctrl <= (ctrl & ~wmask) | ({26'h0000000, avs_writedata[5:0]} & wmask);
                    `SFI_OFF_LINK_MASK: link_mask <= (link_mask & ~wmask[NP-1:0])
                        | (avs_writedata[NP-1:0] & wmask[NP-1:0]);
                    `SFI_OFF_PORT_MODE: port_mode <= (port_mode & ~wmask[2*NP-1:0])
                        | (avs_writedata[2*NP-1:0] & wmask[2*NP-1:0]);
                    default: ctrl <= ctrl;
                endcase
            end
        end else begin
            bus_phase <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
    end

endmodule // sfi_indicator

// File: verilog/sfi_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * switch fault and status indicator block.
 * Assumes a 100 MHz system clock and a byte-addressed Avalon-MM slave.
 */
`ifndef SFI_REGS_VH
`define SFI_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SFI_OFF_CTRL 8'h00
`define SFI_OFF_LINK_MASK 8'h04
`define SFI_OFF_PORT_MODE 8'h08
`define SFI_OFF_STATUS 8'h0C
`define SFI_OFF_PORT_STAT 8'h10

// ****************************************************************
// Control register fields
// ****************************************************************
`define SFI_CTRL_MANUAL_EN 0
`define SFI_CTRL_MANUAL_OPEN 1
`define SFI_CTRL_RING_MON_EN 2
`define SFI_CTRL_RM_EN 3
`define SFI_CTRL_STANDBY_EN 4
`define SFI_CTRL_BOOT_DONE 5
`define SFI_CTRL_RESET 32'h00000000

// ****************************************************************
// Status register fields
// ****************************************************************
`define SFI_ST_CONTACT_OPEN 0
`define SFI_ST_FAULT 1
`define SFI_ST_SUPPLY_ONE 2
`define SFI_ST_SUPPLY_TWO 3
`define SFI_ST_SELFTEST 4
`define SFI_ST_STARTUP 5

// ****************************************************************
// Port count and mode encodings
// ****************************************************************
`define SFI_PORTS 9
`define SFI_MODE_NORMAL 2'h0
`define SFI_MODE_STANDBY 2'h1
`define SFI_MODE_DISABLED 2'h2
`define SFI_LINK_MASK_RESET 9'h000
`define SFI_MODE_RESET 18'h00000

// ****************************************************************
// Timing: clock rate, flash rates, start-up time
// ****************************************************************
`define SFI_CLK_HZ 100000000
`define SFI_SLOW_FLASH_HZ 2
`define SFI_FAST_FLASH_HZ 6
`define SFI_SLOW_HALF (`SFI_CLK_HZ / `SFI_SLOW_FLASH_HZ)
`define SFI_FAST_HALF (`SFI_CLK_HZ / `SFI_FAST_FLASH_HZ)
`define SFI_STARTUP_S 60
`define SFI_ACT_FLASH_MS 50
`define SFI_ACT_CYCLES (`SFI_CLK_HZ / 1000 * `SFI_ACT_FLASH_MS)

`endif

// File: verilog/sfi_timebase.v
/*
 * Free-running time base: one-cycle tick pulses and flash phases.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`include "sfi_regs.vh"

module sfi_timebase #(
    parameter SLOW_HALF = `SFI_SLOW_HALF,
    parameter FAST_HALF = `SFI_FAST_HALF,
    parameter SEC_CYCLES = `SFI_CLK_HZ
) (
    input wire clk_sys,
    input wire rst,
    output reg slow_phase,
    output reg fast_phase,
    output reg sec_tick
);

    reg [31:0] slow_cnt;
    reg [31:0] fast_cnt;
    reg [31:0] sec_cnt;

    // ****************************************************************
    // Dividers
    // ****************************************************************
    // Half-period counters toggle the flash phases
    always @(posedge clk_sys) begin
        if (rst) begin
            slow_cnt <= 32'h00000000;
            fast_cnt <= 32'h00000000;
            sec_cnt <= 32'h00000000;
            slow_phase <= 1'b0;
            fast_phase <= 1'b0;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            if (slow_cnt == SLOW_HALF - 1) begin
                slow_cnt <= 32'h00000000;
                slow_phase <= ~slow_phase;
            end else begin
                slow_cnt <= slow_cnt + 32'h00000001;
            end
            if (fast_cnt == FAST_HALF - 1) begin
                fast_cnt <= 32'h00000000;
                fast_phase <= ~fast_phase;
            end else begin
                fast_cnt <= fast_cnt + 32'h00000001;
            end
            if (sec_cnt == SEC_CYCLES - 1) begin
                sec_cnt <= 32'h00000000;
                sec_tick <= 1'b1;
            end else begin
                sec_cnt <= sec_cnt + 32'h00000001;
            end
        end
    end

endmodule // sfi_timebase

// File: testbench/sfi_indicator_sva.sv
/*
 * Port assertions of the switch fault and status indicator block.
 * Assumes binding to sfi_indicator, one clock, synchronous reset.
 */
`timescale 1ns/100ps

module sfi_indicator_sva (
    input wire clk_sys,
    input wire rst,
    input wire avs_read,
    input wire avs_write,
    input wire [7:0] avs_address,
    input wire avs_waitrequest,
    input wire [1:0] avs_response,
    input wire supply_input_one,
    input wire supply_input_two,
    input wire dev_operational,
    input wire selftest_error,
    input wire ring_port_enabled,
    input wire ring_config_bad,
    input wire led_power_green,
    input wire led_power_yellow,
    input wire led_fault_red,
    input wire led_rm_yellow
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ****************************************************************
    // Sequences
    // ****************************************************************
    sequence bus_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence unmapped_read;
        (avs_read && avs_address > 8'h10) ##1 !avs_waitrequest;
    endsequence
    sequence device_fault;
        !supply_input_one || !supply_input_two || !dev_operational || selftest_error;
    endsequence

    // ****************************************************************
    // Assertions
    // ****************************************************************
    power_green_a: assert property (supply_input_one && supply_input_two |=> led_power_green)
        else $error("power led not green with both supplies");
    power_yellow_a: assert property ((supply_input_one ^ supply_input_two) |=> led_power_yellow && !led_power_green)
        else $error("power led not yellow with one supply");
    power_dark_a: assert property (!supply_input_one && !supply_input_two |=> !led_power_green && !led_power_yellow)
        else $error("power led lit without supplies");
    fault_led_a: assert property (device_fault |=> led_fault_red)
        else $error("fault led dark during a fault");
    rm_yellow_a: assert property (led_rm_yellow |-> $past(ring_port_enabled) && !$past(ring_config_bad))
        else $error("ring led yellow without enabled port");
    bus_answer_a: assert property ($rose(avs_read || avs_write) |-> ##1 bus_ack)
        else $error("bus answer not one cycle long after one cycle");
    bus_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("bus answer without request");
    bus_decode_a: assert property (unmapped_read |-> avs_response == 2'h3)
        else $error("unmapped read not refused");
endmodule // sfi_indicator_sva

// File: testbench/sfi_alarm_monitor.sv
/*
 * External alarm loop watching the relay contact of the indicator block.
 * Assumes the contact level arrives synchronous to clk_sys.
 */
`timescale 1ns/100ps

module sfi_alarm_monitor (
    input wire clk_sys,
    input wire relay_closed,
    output reg alarm_active
);
    // Loop current breaks when the contact opens
    always @(posedge clk_sys) begin
        alarm_active <= !relay_closed;
    end
endmodule // sfi_alarm_monitor

// File: testbench/sfi_indicator_tb.sv
/*
 * Self-checking bench of the indicator block with an alarm loop model.
 * Assumes sfi_regs.vh on the include path and shortened time parameters.
 */
`timescale 1ns/100ps
`include "sfi_regs.vh"

module sfi_indicator_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [1:0] avs_response;
    logic supply_input_one = 1'b1;
    logic supply_input_two = 1'b1;
    logic dev_operational = 1'b1;
    logic selftest_error = 1'b0;
    logic selftest_done = 1'b0;
    logic ring_reserve_lost = 1'b0;
    logic ring_config_bad = 1'b0;
    logic ring_port_enabled = 1'b0;
    logic [8:0] port_link_up = 9'h1FF;
    logic [8:0] port_rx = 9'h000;
    logic [8:0] boot_progress = 9'h000;
    wire relay_closed, led_power_green, led_power_yellow, led_fault_red;
    wire led_rm_green, led_rm_yellow, led_standby_green, alarm_active;
    wire [8:0] port_link_indicator, port_activity_indicator;
    logic [31:0] rdata;
    logic [1:0] rresp;
    int n_fail = 0;
    int n_compared = 0;
    int k;

    // Clock at 100 MHz
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    sfi_indicator #(.SLOW_HALF(10), .FAST_HALF(4), .SEC_CYCLES(20), .STARTUP_S(2), .ACT_CYCLES(6))
        sfi_indicator_inst (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .supply_input_one,
        .supply_input_two, .dev_operational, .selftest_error, .selftest_done, .ring_reserve_lost,
        .ring_config_bad, .ring_port_enabled, .port_link_up, .port_rx, .boot_progress, .relay_closed,
        .led_power_green, .led_power_yellow, .led_fault_red, .led_rm_green, .led_rm_yellow,
        .led_standby_green, .port_link_indicator, .port_activity_indicator);
    sfi_alarm_monitor sfi_alarm_monitor_inst (.clk_sys, .relay_closed, .alarm_active);

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task give_verdict;
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %0s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One Avalon transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int i;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rdata = avs_readdata;
        rresp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            check(0, 1, "bus timeout");
            give_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [1:0] resp);
        bus(1'b0, addr, 32'h00000000);
        check(rdata, exp, "read data");
        check(rresp, resp, "read response");
    endtask

    // Drive fault sources: supply one, supply two, not operational, self-test error
    task automatic set_bad(input logic [3:0] bad);
        @(posedge clk_sys);
        supply_input_one <= !bad[0];
        supply_input_two <= !bad[1];
        dev_operational <= !bad[2];
        selftest_error <= bad[3];
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic relay_is(input logic closed, input logic red);
        repeat (3) @(posedge clk_sys);
        check(relay_closed, closed, "relay contact");
        check(led_fault_red, red, "fault led");
        check(alarm_active, !closed, "alarm loop");
    endtask

    // Length of one steady stretch of a flashing indicator
    task automatic half_period(input int s, input int exp);
        int n;
        logic v;
        @(posedge clk_sys);
        v = (s < 9) ? port_link_indicator[s] : led_rm_green;
        for (n = 0; n < 100 && ((s < 9) ? port_link_indicator[s] : led_rm_green) === v; n++) @(posedge clk_sys);
        v = (s < 9) ? port_link_indicator[s] : led_rm_green;
        for (n = 0; n < 100 && ((s < 9) ? port_link_indicator[s] : led_rm_green) === v; n++) @(posedge clk_sys);
        check(n, exp, "flash half period");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (7) @(posedge clk_sys);
        relay_is(1'b0, 1'b1);
        check(avs_waitrequest, 1'b1, "idle waitrequest");
        rst <= 1'b0;
        boot_progress <= 9'h0A5;
        repeat (3) @(posedge clk_sys);
        check(port_link_indicator, 9'h0A5, "boot display");
        selftest_done <= 1'b1;
        repeat (50) @(posedge clk_sys);
        check(port_link_indicator, 9'h1FF, "link after boot");
        relay_is(1'b1, 1'b0);
        rd(`SFI_OFF_STATUS, 32'h0000002C, 2'h0);
        for (k = 0; k < 4; k++) begin
            set_bad(4'h1 << k);
            relay_is(1'b0, 1'b1);
            check(led_power_yellow, k < 2, "power yellow");
            set_bad(4'h0);
            relay_is(1'b1, 1'b0);
        end
        set_bad(4'h3);
        check({led_power_green, led_power_yellow}, 2'h0, "power dark");
        set_bad(4'h0);
        port_link_up <= 9'h1F7;
        relay_is(1'b1, 1'b0);
        bus(1'b1, `SFI_OFF_LINK_MASK, 32'h00000008);
        relay_is(1'b0, 1'b1);
        rd(`SFI_OFF_LINK_MASK, 32'h00000008, 2'h0);
        port_link_up <= 9'h1FF;
        relay_is(1'b1, 1'b0);
        ring_reserve_lost <= 1'b1;
        relay_is(1'b1, 1'b0);
        bus(1'b1, `SFI_OFF_CTRL, 32'h00000004);
        relay_is(1'b0, 1'b1);
        ring_reserve_lost <= 1'b0;
        ring_config_bad <= 1'b1;
        relay_is(1'b0, 1'b1);
        ring_config_bad <= 1'b0;
        bus(1'b1, `SFI_OFF_CTRL, 32'h0000000C);
        relay_is(1'b0, 1'b1);
        bus(1'b1, `SFI_OFF_CTRL, 32'h00000008);
        relay_is(1'b1, 1'b0);
        check({led_rm_green, led_rm_yellow}, 2'h2, "ring led green");
        ring_port_enabled <= 1'b1;
        relay_is(1'b1, 1'b0);
        check({led_rm_green, led_rm_yellow}, 2'h1, "ring led yellow");
        ring_config_bad <= 1'b1;
        half_period(9, 10);
        ring_config_bad <= 1'b0;
        bus(1'b1, `SFI_OFF_CTRL, 32'h00000011);
        set_bad(4'h1);
        relay_is(1'b1, 1'b1);
        check({led_rm_green, led_rm_yellow, led_standby_green}, 3'h1, "ring dark, standby lit");
        bus(1'b1, `SFI_OFF_CTRL, 32'h00000003);
        set_bad(4'h0);
        relay_is(1'b0, 1'b0);
        bus(1'b1, `SFI_OFF_CTRL, 32'h00000000);
        relay_is(1'b1, 1'b0);
        check(led_standby_green, 1'b0, "standby dark");
        avs_byteenable <= 4'h2;
        bus(1'b1, `SFI_OFF_CTRL, 32'h0000001F);
        avs_byteenable <= 4'hF;
        rd(`SFI_OFF_CTRL, 32'h00000000, 2'h0);
        bus(1'b1, `SFI_OFF_PORT_MODE, 32'h00000009);
        rd(`SFI_OFF_PORT_MODE, 32'h00000009, 2'h0);
        half_period(0, 10);
        half_period(1, 4);
        port_rx <= 9'h004;
        repeat (3) @(posedge clk_sys);
        check(port_activity_indicator, 9'h004, "activity lit");
        repeat (7) @(posedge clk_sys);
        check(port_activity_indicator, 9'h000, "activity flash off");
        repeat (7) @(posedge clk_sys);
        check(port_activity_indicator, 9'h004, "activity flash on");
        port_rx <= 9'h000;
        repeat (20) @(posedge clk_sys);
        check(port_activity_indicator, 9'h000, "activity dark");
        rd(8'h20, 32'h00000000, 2'h3);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(`SFI_OFF_LINK_MASK, 32'h00000000, 2'h0);
        rd(`SFI_OFF_CTRL, 32'h00000000, 2'h0);
        check(port_link_indicator, 9'h0A5, "boot display again");
        bus(1'b1, `SFI_OFF_CTRL, 32'h00000020);
        repeat (2) @(posedge clk_sys);
        check(port_link_indicator, 9'h1FF, "boot override");
        give_verdict();
    end
endmodule // sfi_indicator_tb

bind sfi_indicator sfi_indicator_sva sfi_indicator_sva_inst (.clk_sys, .rst, .avs_read, .avs_write, .avs_address,
    .avs_waitrequest, .avs_response, .supply_input_one, .supply_input_two, .dev_operational, .selftest_error,
    .ring_port_enabled, .ring_config_bad, .led_power_green, .led_power_yellow, .led_fault_red, .led_rm_yellow);
